//--- common/ulmcs_pkg.sv
// ulmcs_pkg: constants and carriers for one uart channel's line/modem control and status block.
// assumes the receive/transmit datapath (shift registers, fifos, baud divider) lives outside
// and talks to this block through the core structs below.
package ulmcs_pkg;

   // register port offsets (three address lines)
   localparam logic [2:0] ULMCS_ADR_DATA  = 3'h0; // rx/tx holding, or divisor low byte
   localparam logic [2:0] ULMCS_ADR_IER   = 3'h1; // interrupt enable, or divisor high byte
   localparam logic [2:0] ULMCS_ADR_ISR   = 3'h2; // interrupt status read, fifo control write
   localparam logic [2:0] ULMCS_ADR_LFC   = 3'h3; // line_format_control
   localparam logic [2:0] ULMCS_ADR_MLC   = 3'h4; // modem_line_control
   localparam logic [2:0] ULMCS_ADR_LST   = 3'h5; // line_status
   localparam logic [2:0] ULMCS_ADR_MIS   = 3'h6; // modem_input_status
   localparam logic [2:0] ULMCS_ADR_SPR   = 3'h7; // scratch

   // reset values
   localparam logic [7:0] ULMCS_RST_LFC   = 8'h00;
   localparam logic [7:0] ULMCS_RST_MLC   = 8'h00;
   localparam logic [7:0] ULMCS_RST_IER   = 8'h00;
   localparam logic [7:0] ULMCS_RST_DIV   = 8'h00;
   localparam logic [7:0] ULMCS_RST_SPR   = 8'hff;
   localparam logic [1:0] ULMCS_RST_PSC   = 2'h0;

   // field positions
   localparam int ULMCS_LFC_PEN  = 3;
   localparam int ULMCS_LFC_EPS  = 4;
   localparam int ULMCS_LFC_STK  = 5;
   localparam int ULMCS_LFC_BRK  = 6;
   localparam int ULMCS_LFC_DLAB = 7;
   localparam int ULMCS_MLC_DTR  = 0;
   localparam int ULMCS_MLC_RTS  = 1;
   localparam int ULMCS_MLC_OUT1 = 2;
   localparam int ULMCS_MLC_IOE  = 3;
   localparam int ULMCS_MLC_LOOP = 4;
   localparam int ULMCS_MLC_ANY  = 5;
   localparam int ULMCS_MLC_IR   = 6;
   localparam int ULMCS_MLC_PSC  = 7;
   localparam int ULMCS_IER_LS   = 2;
   localparam int ULMCS_IER_MS   = 3;

   // prescaler: one baud-generator enable every four clocks when selected
   localparam logic [1:0] ULMCS_PSC_LAST = 2'h3;

   // from the datapath to this block
   typedef struct packed {
      logic       rx_done;        // receive shift register completed a character (pulse)
      logic [7:0] rx_shift_data;  // that character
      logic       rx_shift_par;   // its received parity bit
      logic       rx_break_char;  // that character was a break (all zero, no stop bit)
      logic       rx_flow_char;   // it is a flow-control character and sw flow control is on
      logic       rx_full;        // receive fifo (or holding register) full
      logic       rx_avail;       // at least one character held
      logic       rx_head_new;    // a new character reached the holding position (pulse)
      logic       head_pe;        // holding-position character tags
      logic       head_fe;
      logic       head_bi;
      logic [7:0] rx_head_data;   // holding-position character
      logic       fifo_mode;
      logic       fifo_err_any;   // some byte in the receive fifo carries an error tag
      logic       tx_load_shift;  // holding byte moved to transmit shift register (pulse)
      logic       tx_fifo_empty;
      logic       tx_shift_empty;
      logic       tx_serial;      // serial bit from transmit shift register
      logic [7:0] tx_data;        // character about to be shifted, for parity
      logic       ir_window;      // 3/16 bit-time window for the infrared encoder
      logic       auto_rts_high;  // automatic flow control wants request-to-send inactive
      logic [7:0] isr;            // interrupt status byte
      logic       core_irq;       // other interrupt sources of the channel
   } ulmcs_core_in_t;

   // from this block to the datapath
   typedef struct packed {
      logic        rx_push;      // store the completed character (pulse)
      logic        rx_read;      // host read the holding position (pulse)
      logic        thr_write;    // host loaded a transmit byte (pulse)
      logic [7:0]  thr_data;
      logic        fcr_write;    // host wrote fifo control (pulse)
      logic [15:0] divisor;
      logic        baud_en;      // prescaled clock enable for the baud generator
      logic        rx_line;      // receive line after loopback / infrared routing
      logic        tx_par;       // parity bit for tx_data
      logic        rx_perr;      // parity check result for the last completed character
      logic        resume_tx;    // any-character resume (pulse)
      logic [2:0]  format;       // word length and stop bits
   } ulmcs_core_out_t;

   // modem inputs, all active low at the pins
   typedef struct packed {
      logic cts_n;
      logic dsr_n;
      logic ri_n;
      logic cd_n;
   } ulmcs_modem_t;

   typedef struct packed {
      logic [7:0] lfc;
      logic [7:0] mlc;
      logic [7:0] interrupt_enable_reg;
      logic [7:0] dll;
      logic [7:0] divisor_high_byte;
      logic [7:0] spr;
      logic [7:0] rdata;
      logic       thre;
      logic       oe;
      logic       pe;
      logic       fe;
      logic       bi;
      logic       brk;
      logic       rd_q;
      logic       wr_q;
      logic [3:0] mprev;
      logic [3:0] delta;
      logic [1:0] pscnt;
      logic       baud_en;
      logic       tx_par;
      logic       rx_perr;
      logic       txd;
      logic       irtx;
   } ulmcs_state_t;

endpackage : ulmcs_pkg

//--- rtl/ulmcs_line_modem.sv
// ulmcs_line_modem: line format, modem control, line and modem status of one uart channel.
// assumes a synchronous host port (strobes sampled on clk_i) and a datapath that supplies the
// receive/transmit events in ulmcs_core_in_t.
`timescale 1ns/1ps

module ulmcs_line_modem (
   input  wire logic                     clk_i,         // 40 MHz channel clock
   input  wire logic                     rst_n_i,       // synchronous reset, active low
   input  wire logic                     ce_i,          // clock enable, freezes all state when low
   input  wire logic                     cs_n_i,        // channel select
   input  wire logic                     rd_n_i,        // read strobe
   input  wire logic                     wr_n_i,        // write strobe
   input  wire logic [2:0]               addr_i,        // register offset
   input  wire logic [7:0]               data_i,        // data bus in
   output      logic [7:0]               data_o,        // data bus out, registered
   output      logic                     data_oe_n_o,   // low while driving the data bus
   input  wire logic                     interrupt_output_select_i,      // interrupt output select pin
   output      logic                     int_o,         // channel interrupt
   output      logic                     int_oe_n_o,    // low while the interrupt pin is driven
   input  wire ulmcs_pkg::ulmcs_modem_t  modem_i,       // modem inputs
   output      logic                     dtr_n_o,       // terminal ready
   output      logic                     rts_n_o,       // request to send
   input  wire logic                     rxd_i,         // serial receive pin
   input  wire logic                     irrx_i,        // infrared receive pin
   output      logic                     txd_o,         // serial transmit pin, registered
   output      logic                     irtx_o,        // infrared transmit pin, registered
   input  wire ulmcs_pkg::ulmcs_core_in_t  core_i,      // datapath events
   output      ulmcs_pkg::ulmcs_core_out_t core_o       // datapath controls
);
   import ulmcs_pkg::*;

   ulmcs_state_t st_reg;
   ulmcs_state_t st_next;
   logic         rd_act;
   logic         wr_act;
   logic         rd_go;
   logic         wr_go;
   logic         dlab;
   logic         loop;
   logic [3:0]   mstat;
   logic [7:0]   line_status;
   logic [7:0]   modem_input_status;
   logic [7:0]   rmux;
   logic         tx_int;
   logic         ls_irq;
   logic         ms_irq;

   // parity bit for a character of the programmed length
   function automatic logic par_calc(input logic [7:0] d, input logic [7:0] lfc);
      logic [7:0] m;
      m = d & (8'h1f | {lfc[1:0] == 2'h3, lfc[1], lfc[1:0] != 2'h0, 5'h00});
      if (lfc[ULMCS_LFC_STK]) begin
         par_calc = ~lfc[ULMCS_LFC_EPS];
      end else begin
         par_calc = lfc[ULMCS_LFC_EPS] ? ^m : ~^m;
      end
   endfunction : par_calc

   ////////////////////////////////////////////////////////////////////////////
   // host port decode
   assign rd_act = ~cs_n_i & ~rd_n_i;
   assign wr_act = ~cs_n_i & ~wr_n_i;
   assign rd_go  = ce_i & rd_act & ~st_reg.rd_q;
   assign wr_go  = ce_i & wr_act & ~st_reg.wr_q;
   assign dlab   = st_reg.lfc[ULMCS_LFC_DLAB];
   assign loop   = st_reg.mlc[ULMCS_MLC_LOOP];

   // modem input state, replaced by control bits in loopback
   always_comb begin
      if (loop) begin
         mstat = {st_reg.mlc[ULMCS_MLC_IOE],
                  st_reg.mlc[ULMCS_MLC_OUT1],
                  st_reg.mlc[ULMCS_MLC_DTR],
                  st_reg.mlc[ULMCS_MLC_RTS]};
      end else begin
         mstat = ~{modem_i.cd_n, modem_i.ri_n, modem_i.dsr_n, modem_i.cts_n};
      end
   end

   assign tx_int = st_reg.lfc[ULMCS_LFC_BRK] ? 1'b0 : core_i.tx_serial;
   assign line_status = {core_i.fifo_mode & core_i.fifo_err_any,
                 (core_i.fifo_mode ? core_i.tx_fifo_empty : st_reg.thre)
                    & core_i.tx_shift_empty,
                 core_i.fifo_mode ? core_i.tx_fifo_empty : st_reg.thre,
                 st_reg.bi, st_reg.fe, st_reg.pe, st_reg.oe,
                 core_i.rx_avail};
   assign modem_input_status = {mstat, st_reg.delta};
   assign ls_irq = st_reg.interrupt_enable_reg[ULMCS_IER_LS] & (st_reg.oe | st_reg.pe | st_reg.fe | st_reg.bi);
   assign ms_irq = st_reg.interrupt_enable_reg[ULMCS_IER_MS] & (|st_reg.delta);

   // read data selection
   always_comb begin
      if (addr_i == ULMCS_ADR_DATA) begin
         rmux = dlab ? st_reg.dll : core_i.rx_head_data;
      end else if (addr_i == ULMCS_ADR_IER) begin
         rmux = dlab ? st_reg.divisor_high_byte : st_reg.interrupt_enable_reg;
      end else if (addr_i == ULMCS_ADR_ISR) begin
         rmux = core_i.isr;
      end else if (addr_i == ULMCS_ADR_LFC) begin
         rmux = st_reg.lfc;
      end else if (addr_i == ULMCS_ADR_MLC) begin
         rmux = st_reg.mlc;
      end else if (addr_i == ULMCS_ADR_LST) begin
         rmux = line_status;
      end else if (addr_i == ULMCS_ADR_MIS) begin
         rmux = modem_input_status;
      end else begin
         rmux = st_reg.spr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_next      = st_reg;
      st_next.rd_q = rd_act;
      st_next.wr_q = wr_act;
      if (rd_go) begin
         st_next.rdata = rmux;
      end
      // writes take the data present when the strobe falls
      if (wr_go) begin
         if (addr_i == ULMCS_ADR_DATA) begin
            if (dlab) begin
               st_next.dll = data_i;
            end
         end else if (addr_i == ULMCS_ADR_IER) begin
            if (dlab) begin
               st_next.divisor_high_byte = data_i;
            end else begin
               st_next.interrupt_enable_reg = data_i;
            end
         end else if (addr_i == ULMCS_ADR_LFC) begin
            st_next.lfc = data_i;
         end else if (addr_i == ULMCS_ADR_MLC) begin
            st_next.mlc = data_i;
         end else if (addr_i == ULMCS_ADR_SPR) begin
            st_next.spr = data_i;
         end
      end
      // read clears first, hardware sets afterwards so a set in the same cycle wins
      if (rd_go && addr_i == ULMCS_ADR_LST) begin
         st_next.oe = 1'b0;
         st_next.pe = 1'b0;
         st_next.fe = 1'b0;
         st_next.bi = st_reg.brk;
      end
      if (rd_go && addr_i == ULMCS_ADR_MIS) begin
         st_next.delta = 4'h0;
      end
      if (wr_go && addr_i == ULMCS_ADR_DATA && !dlab) begin
         st_next.thre = 1'b0;
      end
      if (core_i.tx_load_shift) begin
         st_next.thre = 1'b1;
      end
      if (core_i.rx_done && core_i.rx_full) begin
         st_next.oe = 1'b1;
      end
      if (core_i.rx_head_new) begin
         st_next.pe = st_next.pe | core_i.head_pe;
         st_next.fe = st_next.fe | core_i.head_fe;
         st_next.bi = st_next.bi | core_i.head_bi;
      end
      // break stays armed until the routed receive line returns to mark
      if (core_i.rx_done && core_i.rx_break_char) begin
         st_next.brk = 1'b1;
      end else if (core_o.rx_line) begin
         st_next.brk = 1'b0;
      end
      st_next.mprev = mstat;
      st_next.delta[0] = st_next.delta[0] | (mstat[0] ^ st_reg.mprev[0]);
      st_next.delta[1] = st_next.delta[1] | (mstat[1] ^ st_reg.mprev[1]);
      st_next.delta[2] = st_next.delta[2] | (st_reg.mprev[2] & ~mstat[2]);
      st_next.delta[3] = st_next.delta[3] | (mstat[3] ^ st_reg.mprev[3]);
      st_next.pscnt   = st_reg.pscnt + 2'h1;
      st_next.baud_en = ~st_reg.mlc[ULMCS_MLC_PSC] | (st_reg.pscnt == ULMCS_PSC_LAST);
      st_next.tx_par  = par_calc(core_i.tx_data, st_reg.lfc);
      st_next.rx_perr = st_reg.lfc[ULMCS_LFC_PEN]
                        & (par_calc(core_i.rx_shift_data, st_reg.lfc) != core_i.rx_shift_par);
      // loopback parks the pin at mark; infrared idles at 0 and pulses only for space bits
      st_next.txd  = loop | st_reg.mlc[ULMCS_MLC_IR] | tx_int;
      st_next.irtx = ~loop & st_reg.mlc[ULMCS_MLC_IR] & ~tx_int & core_i.ir_window;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_reg         <= '0;
         st_reg.lfc     <= ULMCS_RST_LFC;
         st_reg.mlc     <= ULMCS_RST_MLC;
         st_reg.interrupt_enable_reg     <= ULMCS_RST_IER;
         st_reg.dll     <= ULMCS_RST_DIV;
         st_reg.divisor_high_byte     <= ULMCS_RST_DIV;
         st_reg.spr     <= ULMCS_RST_SPR;
         st_reg.pscnt   <= ULMCS_RST_PSC;
         st_reg.thre    <= 1'b1;
         st_reg.txd     <= 1'b1;
         st_reg.rd_q    <= 1'b1;
         st_reg.wr_q    <= 1'b1;
         // sampled so that no change flag fires on the first cycle after reset
         st_reg.mprev   <= ~{modem_i.cd_n, modem_i.ri_n, modem_i.dsr_n, modem_i.cts_n};
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign data_o      = st_reg.rdata;
   assign data_oe_n_o = ~rd_act;
   assign int_o       = ls_irq | ms_irq | core_i.core_irq;
   assign int_oe_n_o  = ~(interrupt_output_select_i | st_reg.mlc[ULMCS_MLC_IOE]);
   assign dtr_n_o     = loop | ~st_reg.mlc[ULMCS_MLC_DTR];
   assign rts_n_o     = loop | ~st_reg.mlc[ULMCS_MLC_RTS] | core_i.auto_rts_high;
   assign txd_o       = st_reg.txd;
   assign irtx_o      = st_reg.irtx;

   always_comb begin
      core_o           = '0;
      // only the first character of a break run is stored; flow characters never are
      core_o.rx_push   = ce_i & core_i.rx_done & ~core_i.rx_full
                         & ~(st_reg.brk & core_i.rx_break_char) & ~core_i.rx_flow_char;
      core_o.rx_read   = rd_go & (addr_i == ULMCS_ADR_DATA) & ~dlab;
      core_o.thr_write = wr_go & (addr_i == ULMCS_ADR_DATA) & ~dlab;
      core_o.thr_data  = data_i;
      core_o.fcr_write = wr_go & (addr_i == ULMCS_ADR_ISR);
      core_o.divisor   = {st_reg.divisor_high_byte, st_reg.dll};
      core_o.baud_en   = st_reg.baud_en;
      core_o.rx_line   = loop ? tx_int : (st_reg.mlc[ULMCS_MLC_IR] ? ~irrx_i : rxd_i);
      core_o.tx_par    = st_reg.tx_par;
      core_o.rx_perr   = st_reg.rx_perr;
      core_o.resume_tx = ce_i & st_reg.mlc[ULMCS_MLC_ANY] & core_i.rx_done;
      core_o.format    = st_reg.lfc[2:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_par_sense;
      ce_i && st_reg.lfc[5:3] == 3'b001 && st_reg.lfc[1:0] == 2'h3
      |=> core_o.tx_par == ~^$past(core_i.tx_data);
   endproperty
   a_par_sense: assert property (p_par_sense) else $error("odd parity bit wrong");

   property p_par_force;
      ce_i && st_reg.lfc[ULMCS_LFC_STK] |=> core_o.tx_par == ~$past(st_reg.lfc[ULMCS_LFC_EPS]);
   endproperty
   a_par_force: assert property (p_par_force) else $error("forced parity wrong");

   property p_break;
      ce_i && st_reg.lfc[ULMCS_LFC_BRK] && !loop && !st_reg.mlc[ULMCS_MLC_IR] |=> !txd_o;
   endproperty
   a_break: assert property (p_break) else $error("break not held on txd");

   property p_dlab_write;
      wr_go && addr_i == ULMCS_ADR_DATA && dlab |-> !core_o.thr_write ##1 st_reg.dll == $past(data_i);
   endproperty
   a_dlab_write: assert property (p_dlab_write) else $error("divisor write misrouted");

   property p_dtr;
      wr_go && addr_i == ULMCS_ADR_MLC && data_i[1:0] == 2'h1 && !data_i[ULMCS_MLC_LOOP]
      |=> !dtr_n_o && (rts_n_o || core_i.auto_rts_high) == 1'b1;
   endproperty
   a_dtr: assert property (p_dtr) else $error("modem outputs not inverse of control");

   property p_prescale;
      ce_i && st_reg.mlc[ULMCS_MLC_PSC] && core_o.baud_en && $past(st_reg.mlc[ULMCS_MLC_PSC])
      |=> !core_o.baud_en;
   endproperty
   a_prescale: assert property (p_prescale) else $error("prescaler enable too often");

   property p_overrun;
      ce_i && core_i.rx_done && core_i.rx_full |-> !core_o.rx_push ##1 st_reg.oe && line_status[1];
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");

   property p_temt;
      line_status[6] |-> line_status[5] && core_i.tx_shift_empty;
   endproperty
   a_temt: assert property (p_temt) else $error("transmitter empty while data held");

   property p_ring_edge;
      ce_i && st_reg.mprev[2] && !mstat[2] |=> st_reg.delta[2] && (ms_irq == st_reg.interrupt_enable_reg[ULMCS_IER_MS]);
   endproperty
   a_ring_edge: assert property (p_ring_edge) else $error("ring change missed");

   property p_lsr_clear;
      rd_go && addr_i == ULMCS_ADR_LST && !core_i.rx_done && !core_i.rx_head_new && !st_reg.brk
      |=> !st_reg.oe && !st_reg.pe && !st_reg.fe && !st_reg.bi && !ls_irq;
   endproperty
   a_lsr_clear: assert property (p_lsr_clear) else $error("line status read did not clear");

   property p_msr_clear;
      rd_go && addr_i == ULMCS_ADR_MIS && mstat == st_reg.mprev |=> st_reg.delta == 4'h0 && !ms_irq;
   endproperty
   a_msr_clear: assert property (p_msr_clear) else $error("modem status read did not clear");

   property p_int_oe;
      int_oe_n_o == !(interrupt_output_select_i || st_reg.mlc[ULMCS_MLC_IOE]);
   endproperty
   a_int_oe: assert property (p_int_oe) else $error("interrupt output enable wrong");

   // loopback must never leak the modem outputs or the pin level into the receiver
   property p_loopback;
      loop |-> dtr_n_o && rts_n_o && core_o.rx_line == (core_i.tx_serial && !st_reg.lfc[ULMCS_LFC_BRK]);
   endproperty
   a_loopback: assert property (p_loopback) else $error("loopback routing wrong");

   property p_thr_load;
      wr_go && addr_i == ULMCS_ADR_DATA && !dlab && !core_i.tx_load_shift
      |=> core_i.fifo_mode || (!line_status[5] && !line_status[6]);
   endproperty
   a_thr_load: assert property (p_thr_load) else $error("holding empty not cleared by load");

   c_overrun: cover property (ce_i && core_i.rx_done && core_i.rx_full);
   c_break:   cover property (st_reg.brk ##1 st_reg.bi ##[1:20] !st_reg.brk);
   c_loop:    cover property (loop && ms_irq);
   c_irq_oe:  cover property (!int_oe_n_o && int_o);

endmodule : ulmcs_line_modem

//--- testbench/ulmcs_modem_model.sv
// ulmcs_modem_model: far-side modem, drives the modem pins, the serial line and an idle infrared line.
// assumes the bench states the wanted pin levels; they reach the pins off the sampling edge.
`timescale 1ns/1ps
module ulmcs_modem_model (
   input  wire logic                    clk_i,   // channel clock
   input  wire ulmcs_pkg::ulmcs_modem_t req_i,   // wanted pin levels
   input  wire logic                    line_i,  // wanted serial line level
   output      ulmcs_pkg::ulmcs_modem_t modem_o, // modem pins, active low
   output      logic                    rxd_o,   // serial line, mark while idle
   output      logic                    irrx_o   // infrared line, no pulse while idle
);
   import ulmcs_pkg::*;
   initial modem_o = '1;
   initial rxd_o = 1'b1;
   always @(negedge clk_i) modem_o <= req_i;
   always @(negedge clk_i) rxd_o <= line_i;
   assign irrx_o = 1'b0;
endmodule : ulmcs_modem_model

//--- testbench/tb_top.sv
// tb_top: self-checking bench for the line/modem control and status block.
// assumes the datapath side is played by the bench through core_i.
`timescale 1ns/1ps
module tb_top;
   import ulmcs_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdat = 8'h00, data_o;
   logic ce = 1'b1, interrupt_output_select = 1'b0, line = 1'b1;
   logic dtr_n, rts_n, txd, int_oe_n, rxd, irrx, irq, oe_n, irtx;
   ulmcs_modem_t req = '1, modem;
   ulmcs_core_in_t ci = '0;
   ulmcs_core_out_t co;
   int n_fail = 0, num_checks = 0;
   always #12.5 clk = ~clk;
   ulmcs_modem_model u_modem (.clk_i(clk), .req_i(req), .line_i(line), .modem_o(modem), .rxd_o(rxd),
      .irrx_o(irrx));
   ulmcs_line_modem u_dut (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .cs_n_i(cs_n), .rd_n_i(rd_n),
      .wr_n_i(wr_n), .addr_i(addr), .data_i(wdat), .data_o(data_o), .data_oe_n_o(oe_n), .interrupt_output_select_i(interrupt_output_select),
      .int_o(irq), .int_oe_n_o(int_oe_n), .modem_i(modem), .dtr_n_o(dtr_n), .rts_n_o(rts_n), .rxd_i(rxd),
      .irrx_i(irrx), .txd_o(txd), .irtx_o(irtx), .core_i(ci), .core_o(co));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      addr = a; cs_n = 1'b0; rd_n = 1'b0;
      repeat (2) @(negedge clk);
      chk(data_o, exp);
      chk({7'h0, oe_n}, 8'h00);
      cs_n = 1'b1; rd_n = 1'b1;
      @(negedge clk);
   endtask : rd
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      addr = a; wdat = v; cs_n = 1'b0; wr_n = 1'b0;
      @(negedge clk);
      cs_n = 1'b1; wr_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask : wr
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(ULMCS_ADR_LFC, 8'h00);
      rd(ULMCS_ADR_MLC, 8'h00);
      rd(ULMCS_ADR_LST, 8'h60);
      chk({5'h0, txd, dtr_n, rts_n}, 8'h07);
      chk({6'h0, irq, int_oe_n}, 8'h01);
   endtask : t_reset
   task automatic t_format;
      logic [7:0] lfc [5] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h0b};
      logic       par [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      // upper bits set so that a missing word-length mask flips the 5-bit parity
      ci.tx_data = 8'he1;
      for (int i = 0; i < 5; i++) begin
         wr(ULMCS_ADR_LFC, lfc[i]);
         chk({7'h0, co.tx_par}, {7'h0, par[i]});
      end
      wr(ULMCS_ADR_LFC, 8'h40);
      chk({7'h0, txd}, 8'h00);
      wr(ULMCS_ADR_LFC, 8'h80);
      wr(ULMCS_ADR_DATA, 8'h34);
      wr(ULMCS_ADR_IER, 8'h12);
      chk(co.divisor[15:8], 8'h12);
      chk(co.divisor[7:0], 8'h34);
      wr(ULMCS_ADR_LFC, 8'h00);
      rd(ULMCS_ADR_IER, 8'h00);
      chk({7'h0, txd}, 8'h01);
   endtask : t_format
   task automatic t_modem;
      wr(ULMCS_ADR_MLC, 8'h01);
      chk({6'h0, dtr_n, rts_n}, 8'h01);
      wr(ULMCS_ADR_MLC, 8'h03);
      chk({6'h0, dtr_n, rts_n}, 8'h00);
      chk({7'h0, int_oe_n}, 8'h01);
      interrupt_output_select = 1'b1;
      @(negedge clk);
      chk({7'h0, int_oe_n}, 8'h00);
      interrupt_output_select = 1'b0;
      wr(ULMCS_ADR_MLC, 8'h08);
      chk({7'h0, int_oe_n}, 8'h00);
      wr(ULMCS_ADR_IER, 8'h08);
      req.cts_n = 1'b0;
      repeat (3) @(negedge clk);
      chk({7'h0, irq}, 8'h01);
      rd(ULMCS_ADR_MIS, 8'h11);
      rd(ULMCS_ADR_MIS, 8'h10);
      chk({7'h0, irq}, 8'h00);
      req.ri_n = 1'b0;
      repeat (3) @(negedge clk);
      rd(ULMCS_ADR_MIS, 8'h50);
      req.ri_n = 1'b1;
      repeat (3) @(negedge clk);
      rd(ULMCS_ADR_MIS, 8'h14);
      wr(ULMCS_ADR_MLC, 8'h1c);
      rd(ULMCS_ADR_MIS, 8'hc9);
      chk({5'h0, txd, dtr_n, rts_n}, 8'h07);
      ci.tx_serial = 1'b0;
      @(negedge clk);
      chk({6'h0, txd, co.rx_line}, 8'h02);
      ci.tx_serial = 1'b1;
      wr(ULMCS_ADR_MLC, 8'h14);
      rd(ULMCS_ADR_MIS, 8'h48);
      wr(ULMCS_ADR_MLC, 8'h00);
      rd(ULMCS_ADR_MIS, 8'h15);
      wr(ULMCS_ADR_IER, 8'h00);
   endtask : t_modem
   task automatic t_clock;
      logic [7:0] n;
      for (int i = 0; i < 2; i++) begin
         wr(ULMCS_ADR_MLC, i ? 8'h00 : 8'h80);
         n = 8'h00;
         repeat (8) begin
            @(negedge clk);
            n = n + {7'h0, co.baud_en};
         end
         chk(n, i ? 8'h08 : 8'h02);
      end
      wr(ULMCS_ADR_MLC, 8'h40);
      ci.ir_window = 1'b1;
      ci.tx_serial = 1'b0;
      repeat (2) @(negedge clk);
      chk({5'h0, txd, irtx, co.rx_line}, 8'h07);
      ci.tx_serial = 1'b1;
      repeat (2) @(negedge clk);
      chk({5'h0, txd, irtx, co.rx_line}, 8'h05);
      wr(ULMCS_ADR_MLC, 8'h00);
      ci.ir_window = 1'b0;
      // a write strobe seen only while the enable is low must be lost
      ce = 1'b0;
      wr(ULMCS_ADR_SPR, 8'h5a);
      ce = 1'b1;
      rd(ULMCS_ADR_SPR, 8'hff);
   endtask : t_clock
   task automatic t_line;
      wr(ULMCS_ADR_IER, 8'h04);
      ci.rx_done = 1'b1; ci.rx_full = 1'b1;
      #1 chk({7'h0, co.rx_push}, 8'h00);
      @(negedge clk);
      ci.rx_done = 1'b0; ci.rx_full = 1'b0;
      chk({7'h0, irq}, 8'h01);
      rd(ULMCS_ADR_LST, 8'h62);
      rd(ULMCS_ADR_LST, 8'h60);
      chk({7'h0, irq}, 8'h00);
      ci.rx_avail = 1'b1; ci.rx_head_new = 1'b1; ci.head_pe = 1'b1; ci.head_fe = 1'b1;
      @(negedge clk);
      ci.rx_head_new = 1'b0;
      chk({7'h0, irq}, 8'h01);
      rd(ULMCS_ADR_LST, 8'h6d);
      ci.head_pe = 1'b0; ci.head_fe = 1'b0; ci.rx_avail = 1'b0;
      ci.fifo_mode = 1'b1; ci.fifo_err_any = 1'b1; ci.tx_fifo_empty = 1'b0;
      rd(ULMCS_ADR_LST, 8'h80);
      rd(ULMCS_ADR_LST, 8'h80);
      ci.fifo_err_any = 1'b0; ci.tx_fifo_empty = 1'b1;
      rd(ULMCS_ADR_LST, 8'h60);
      ci.fifo_mode = 1'b0;
      wr(ULMCS_ADR_DATA, 8'h55);
      rd(ULMCS_ADR_LST, 8'h00);
      ci.tx_load_shift = 1'b1; ci.tx_shift_empty = 1'b0;
      @(negedge clk);
      ci.tx_load_shift = 1'b0;
      rd(ULMCS_ADR_LST, 8'h20);
      ci.tx_shift_empty = 1'b1;
      line = 1'b0;
      @(negedge clk);
      ci.rx_done = 1'b1; ci.rx_break_char = 1'b1; ci.rx_head_new = 1'b1; ci.head_bi = 1'b1;
      #1 chk({7'h0, co.rx_push}, 8'h01);
      @(negedge clk);
      ci.rx_head_new = 1'b0; ci.head_bi = 1'b0;
      #1 chk({7'h0, co.rx_push}, 8'h00);
      @(negedge clk);
      ci.rx_done = 1'b0; ci.rx_break_char = 1'b0;
      rd(ULMCS_ADR_LST, 8'h70);
      rd(ULMCS_ADR_LST, 8'h70);
      line = 1'b1;
      repeat (2) @(negedge clk);
      rd(ULMCS_ADR_LST, 8'h70);
      rd(ULMCS_ADR_LST, 8'h60);
      wr(ULMCS_ADR_MLC, 8'h20);
      ci.rx_done = 1'b1; ci.rx_flow_char = 1'b1;
      #1 chk({6'h0, co.resume_tx, co.rx_push}, 8'h02);
      ci.rx_flow_char = 1'b0;
      #1 chk({6'h0, co.resume_tx, co.rx_push}, 8'h03);
      @(negedge clk);
      ci.rx_done = 1'b0;
      wr(ULMCS_ADR_MLC, 8'h00);
   endtask : t_line
   task automatic results;
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results
   initial begin
      ci.tx_shift_empty = 1'b1;
      ci.tx_serial = 1'b1;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_reset;
      t_format;
      t_modem;
      t_clock;
      t_line;
      results;
   end
   initial begin
      #100us;
      n_fail++;
      results;
   end
endmodule : tb_top
